/* common/hmss_defines.vh */
`ifndef HMSS_DEFINES_VH
`define HMSS_DEFINES_VH
// ----------------------------------------
// Fault vector bit positions
// ----------------------------------------
`define HMSS_F_VALID   0
`define HMSS_F_PARITY  1
`define HMSS_F_BIPHASE 2
`define HMSS_F_CONF    3
`define HMSS_F_QCHK    4
`define HMSS_F_CSCHK   5
`define HMSS_F_UNLOCK  6
`define HMSS_NFAULT    7
// ----------------------------------------
// Mode numbers and emphasis code
// ----------------------------------------
`define HMSS_MODE_W    3
`define HMSS_MODE_NONE 3'h0
`define HMSS_MODE1     3'h1
`define HMSS_MODE2     3'h2
`define HMSS_MODE3     3'h3
`define HMSS_MODE4     3'h4
`define HMSS_MODE5     3'h5
`define HMSS_MODE6     3'h6
`define HMSS_PREEMPHASIS_INDICATOR_5015 3'h1
// ----------------------------------------
// Format word: sf,res[1:0],just,del,spol,lrpol
// ----------------------------------------
`define HMSS_FMT_W     7
`define HMSS_OF1       7'h0_002
`define HMSS_OF2       7'h0_005
`define HMSS_OF3       7'h0_008
`define HMSS_OF4       7'h0_025
`define HMSS_OF5       7'h0_032
`define HMSS_IF1       7'h0_002
`define HMSS_IF2       7'h0_005
`define HMSS_IF3       7'h0_008
`define HMSS_IF4       7'h0_028
// ----------------------------------------
// Timing
// ----------------------------------------
`define HMSS_SYNC_MIN  2'h3
`endif

/* logic/hmss_sync2.v */
`timescale 1ns/1ps
`default_nettype none
module hmss_sync2 #(
   parameter W = 1
) (
   // Clock and reset
   input  wire         mclk_i,
   input  wire         rst_n_i,
   // Data
   input  wire [W-1:0] d_i,
   output wire [W-1:0] q_o
);
   reg [W-1:0] meta_r;
   reg [W-1:0] q_r;
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         meta_r <= {W{1'b0}};
         q_r    <= {W{1'b0}};
      end else begin
         meta_r <= d_i;
         q_r    <= meta_r;
      end
   end
   assign q_o = q_r;
endmodule
`default_nettype wire

/* logic/hmss_fmt_map.v */
`timescale 1ns/1ps
`default_nettype none
`include "hmss_defines.vh"
module hmss_fmt_map (
   // Strap selects
   input  wire [1:0] out_sel_i,
   input  wire       out_direct_i,
   input  wire [1:0] in_sel_i,
   input  wire       out_master_i,
   // Decoded formats
   output wire [6:0] out_fmt_o,
   output wire [6:0] in_fmt_o,
   output wire       out_fmt_bad_o
);
   function [6:0] out_fmt;
      input [1:0] s;
      input       direct;
      begin
         if (direct)
            out_fmt = `HMSS_OF5;
         else begin
            case (s)
               2'h0:    out_fmt = `HMSS_OF1;
               2'h1:    out_fmt = `HMSS_OF2;
               2'h2:    out_fmt = `HMSS_OF3;
               default: out_fmt = `HMSS_OF4;
            endcase
         end
      end
   endfunction
   function [6:0] in_fmt;
      input [1:0] s;
      begin
         case (s)
            2'h0:    in_fmt = `HMSS_IF1;
            2'h1:    in_fmt = `HMSS_IF2;
            2'h2:    in_fmt = `HMSS_IF3;
            default: in_fmt = `HMSS_IF4;
         endcase
      end
   endfunction
   assign out_fmt_o     = out_fmt(out_sel_i, out_direct_i);
   assign in_fmt_o      = in_fmt(in_sel_i);
   // EIAJ output needs the port to drive its own clocks
   assign out_fmt_bad_o = ~out_direct_i & (out_sel_i == 2'h2) & ~out_master_i;
endmodule
`default_nettype wire

/* logic/hmss_top.v */
`timescale 1ns/1ps
`default_nettype none
`include "hmss_defines.vh"
module hmss_top (
   // Clock and reset
   input  wire       mclk_i,
   input  wire       rst_n_i,
   // Mode straps (board pins)
   input  wire       hw_mode_strap_i,
   input  wire       flow_select_lo_i,
   input  wire       flow_select_hi_i,
   input  wire       src_serial_sel_i,
   // Start-up strap pins sensed on the third edge after reset release
   input  wire       strap_out_master_i,
   input  wire [1:0] strap_out_fmt_i,
   input  wire [1:0] strap_in_fmt_i,
   input  wire       strap_sync_out_i,
   input  wire       preemphasis_indicator_i,
   // Receiver status from decoder
   input  wire [6:0] rx_fault_i,
   input  wire [6:0] rx_fault_mask_i,
   input  wire       rx_subframe_i,
   input  wire [2:0] rx_preemphasis_indicator_code_i,
   // Transmitter framing
   input  wire       tx_subframe_i,
   input  wire       tx_block_first_i,
   input  wire       sync_out_sw_i,
   // Block-start sync pin
   input  wire       block_start_sync_i,
   output wire       block_start_sync_o,
   output wire       block_start_sync_oe_o,
   output wire       tx_block_restart_o,
   // Line driver
   input  wire       line_driver_pos_i,
   input  wire       line_driver_neg_i,
   output wire       line_driver_pos_o,
   output wire       line_driver_neg_o,
   // Control port pins
   input  wire       addr_pin_zero_i,
   input  wire       addr_pin_one_i,
   input  wire       ctrl_sda_drive_low_i,
   input  wire       ctrl_serial_out_i,
   output wire       ctrl_data_o,
   output wire       ctrl_data_oe_o,
   output wire       ctrl_spi_mode_o,
   output wire [2:0] i2c_addr_o,
   output wire       spi_chip_sel_n_o,
   output wire       spi_data_in_o,
   // Side-channel user data pin
   input  wire       side_pin_dir_bit_i,
   input  wire       user_data_rx_i,
   input  wire       user_pin_i,
   output wire       user_pin_o,
   output wire       user_pin_oe_o,
   output wire       user_data_tx_o,
   // Indicators and decoded configuration
   output wire       rx_fault_flag_o,
   output wire       preemphasis_indicator_o,
   output wire       preemphasis_indicator_oe_o,
   output wire       hw_mode_o,
   output wire [2:0] hw_mode_num_o,
   output wire       out_master_o,
   output wire [6:0] out_fmt_o,
   output wire [6:0] in_fmt_o,
   output wire       out_fmt_bad_o,
   output wire       sync_is_out_o
);
   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   localparam NS = 16;
   wire [NS-1:0] pin_s;
   hmss_sync2 #(.W(NS)) u_sync (
      .mclk_i  (mclk_i),
      .rst_n_i (rst_n_i),
      .d_i     ({hw_mode_strap_i, flow_select_lo_i, flow_select_hi_i, src_serial_sel_i,
                 strap_out_master_i, strap_out_fmt_i, strap_in_fmt_i, strap_sync_out_i,
                 preemphasis_indicator_i, block_start_sync_i, addr_pin_zero_i,
                 addr_pin_one_i, user_pin_i, 1'b0}),
      .q_o     (pin_s)
   );
   wire hw_s    = pin_s[15];
   wire fsl_s   = pin_s[14];
   wire fsh_s   = pin_s[13];
   wire ssel_s  = pin_s[12];
   wire omst_s  = pin_s[11];
   wire [1:0] ofmt_s = pin_s[10:9];
   wire [1:0] ifmt_s = pin_s[8:7];
   wire sout_s  = pin_s[6];
   wire preemphasis_indicator_s  = pin_s[5];
   wire bss_s   = pin_s[4];
   wire a0_s    = pin_s[3];
   wire a1_s    = pin_s[2];
   wire usr_s   = pin_s[1];

   // ----------------------------------------
   // Mode decode
   // ----------------------------------------
   function [2:0] mode_dec;
      input hi;
      input lo;
      input ser;
      begin
         case ({hi, lo})
            2'h0:    mode_dec = ser ? `HMSS_MODE2 : `HMSS_MODE1;
            2'h1:    mode_dec = `HMSS_MODE3;
            2'h2:    mode_dec = `HMSS_MODE4;
            default: mode_dec = ser ? `HMSS_MODE6 : `HMSS_MODE5;
         endcase
      end
   endfunction

   // ----------------------------------------
   // Strap capture after reset release
   // ----------------------------------------
   // Synchroniser delay: straps settle two edges after release, so
   // capture on the third edge, then pins turn to outputs.
   reg [1:0] rcnt_r;
   reg       cap_done_r;
   reg       hw_r;
   reg [2:0] mode_r;
   reg       omst_r;
   reg [1:0] ofmt_r;
   reg [1:0] ifmt_r;
   reg       sout_r;
   reg       addr2_r;
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         rcnt_r     <= 2'h0;
         cap_done_r <= 1'b0;
         hw_r       <= 1'b0;
         mode_r     <= `HMSS_MODE_NONE;
         omst_r     <= 1'b0;
         ofmt_r     <= 2'h0;
         ifmt_r     <= 2'h0;
         sout_r     <= 1'b0;
         addr2_r    <= 1'b0;
      end else if (!cap_done_r) begin
         if (rcnt_r != 2'h2) begin
            rcnt_r <= rcnt_r + 2'h1;
         end else begin
            cap_done_r <= 1'b1;
            hw_r       <= hw_s;
            mode_r     <= hw_s ? mode_dec(fsh_s, fsl_s, ssel_s) : `HMSS_MODE_NONE;
            omst_r     <= omst_s;
            ofmt_r     <= ofmt_s;
            ifmt_r     <= ifmt_s;
            sout_r     <= sout_s;
            addr2_r    <= preemphasis_indicator_s;
         end
      end
   end
   assign hw_mode_o     = hw_r;
   assign hw_mode_num_o = mode_r;
   assign out_master_o  = omst_r;
   // Software mode takes the direction from the control bit instead
   assign sync_is_out_o = hw_r ? sout_r : sync_out_sw_i;

   hmss_fmt_map u_fmt (
      .out_sel_i     (ofmt_r),
      .out_direct_i  (mode_r == `HMSS_MODE4),
      .in_sel_i      (ifmt_r),
      .out_master_i  (omst_r),
      .out_fmt_o     (out_fmt_o),
      .in_fmt_o      (in_fmt_o),
      .out_fmt_bad_o (out_fmt_bad_o)
   );

   // ----------------------------------------
   // Receiver fault flag
   // ----------------------------------------
   wire fault_now = |(rx_fault_i & ~rx_fault_mask_i);
   reg  flag_r;
   always @(posedge mclk_i) begin
      if (!rst_n_i)
         flag_r <= 1'b0;
      else if (rx_subframe_i)
         flag_r <= fault_now;
   end
   assign rx_fault_flag_o = flag_r;

   // ----------------------------------------
   // Pre-emphasis indicator
   // ----------------------------------------
   reg preemphasis_indicator_r;
   always @(posedge mclk_i) begin
      if (!rst_n_i)
         preemphasis_indicator_r <= 1'b1;
      else
         preemphasis_indicator_r <= (rx_preemphasis_indicator_code_i != `HMSS_PREEMPHASIS_INDICATOR_5015);
   end
   assign preemphasis_indicator_o    = preemphasis_indicator_r;
   assign preemphasis_indicator_oe_o = cap_done_r;

   // ----------------------------------------
   // Block-start sync
   // ----------------------------------------
   reg [1:0] bss_cnt_r;
   reg       bss_arm_r;
   reg       bss_out_r;
   reg       restart_r;
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         bss_cnt_r <= 2'h0;
         bss_arm_r <= 1'b0;
         bss_out_r <= 1'b0;
         restart_r <= 1'b0;
      end else begin
         restart_r <= 1'b0;
         if (tx_subframe_i)
            bss_out_r <= tx_block_first_i;
         if (!sync_is_out_o && cap_done_r) begin
            if (!bss_s)
               bss_cnt_r <= 2'h0;
            else if (bss_cnt_r != `HMSS_SYNC_MIN)
               bss_cnt_r <= bss_cnt_r + 2'h1;
            if (bss_s && bss_cnt_r == `HMSS_SYNC_MIN - 2'h1)
               bss_arm_r <= 1'b1;
            else if (tx_subframe_i && bss_arm_r) begin
               bss_arm_r <= 1'b0;
               restart_r <= 1'b1;
            end
         end else begin
            bss_cnt_r <= 2'h0;
            bss_arm_r <= 1'b0;
         end
      end
   end
   assign block_start_sync_o    = bss_out_r;
   assign block_start_sync_oe_o = sync_is_out_o & cap_done_r;
   assign tx_block_restart_o    = restart_r;

   // ----------------------------------------
   // Line driver gating
   // ----------------------------------------
   assign line_driver_pos_o = rst_n_i & cap_done_r & line_driver_pos_i;
   assign line_driver_neg_o = rst_n_i & cap_done_r & line_driver_neg_i;

   // ----------------------------------------
   // Control port protocol select
   // ----------------------------------------
   reg a0_d_r;
   reg spi_r;
   always @(posedge mclk_i) begin
      if (!rst_n_i) begin
         a0_d_r <= 1'b1;
         spi_r  <= 1'b0;
      end else begin
         a0_d_r <= a0_s;
         // Synchroniser reads low until primed; ignore edges before capture
         if (cap_done_r && a0_d_r && !a0_s)
            spi_r <= 1'b1;
      end
   end
   assign ctrl_spi_mode_o  = spi_r;
   assign i2c_addr_o       = {addr2_r, a1_s, a0_s};
   assign spi_chip_sel_n_o = spi_r ? a0_s : 1'b1;
   assign spi_data_in_o    = spi_r ? a1_s : 1'b0;
   // Open drain in I2C: only ever drive low
   assign ctrl_data_o      = spi_r ? ctrl_serial_out_i : 1'b0;
   assign ctrl_data_oe_o   = spi_r ? ~spi_chip_sel_n_o : ctrl_sda_drive_low_i;

   // ----------------------------------------
   // Side-channel user data pin
   // ----------------------------------------
   // Direction bit held low by reset in the register owner
   assign user_pin_oe_o  = side_pin_dir_bit_i & cap_done_r;
   assign user_pin_o     = user_data_rx_i;
   assign user_data_tx_o = side_pin_dir_bit_i ? 1'b0 : usr_s;
endmodule
`default_nettype wire

/* tb/hmss_top_assertions.sv */
`timescale 1ns/1ps
`default_nettype none
module hmss_top_assertions (
   // Clock and reset
   input wire logic       mclk_i,
   input wire logic       rst_n_i,
   // Watched ports
   input wire logic [6:0] rx_fault_i,
   input wire logic [6:0] rx_fault_mask_i,
   input wire logic       rx_subframe_i,
   input wire logic       rx_fault_flag_o,
   input wire logic       tx_subframe_i,
   input wire logic       tx_block_first_i,
   input wire logic       block_start_sync_i,
   input wire logic       block_start_sync_o,
   input wire logic       block_start_sync_oe_o,
   input wire logic       tx_block_restart_o,
   input wire logic       sync_is_out_o,
   input wire logic       line_driver_pos_o,
   input wire logic       line_driver_neg_o,
   input wire logic       ctrl_spi_mode_o,
   input wire logic       ctrl_data_o,
   input wire logic       ctrl_data_oe_o,
   input wire logic       side_pin_dir_bit_i,
   input wire logic       user_pin_oe_o,
   input wire logic [2:0] hw_mode_num_o,
   input wire logic [6:0] out_fmt_o,
   input wire logic [6:0] in_fmt_o
);
   // ----------------------------------------
   // Cycles since reset release
   // ----------------------------------------
   logic [3:0] up_cnt_r;
   logic       settled;
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) up_cnt_r <= 4'h0;
      else if (!settled) up_cnt_r <= up_cnt_r + 4'h1;
   end
   // Capture lands on edge three; margin covers registered outputs
   assign settled = (up_cnt_r == 4'h9);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_sync_held;
      (!sync_is_out_o && block_start_sync_i) [*5];
   endsequence
   sequence s_restart;
      ##[1:80] tx_block_restart_o;
   endsequence
   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_drv_low_rst: assert property (disable iff (1'b0) !rst_n_i |->
      !line_driver_pos_o && !line_driver_neg_o) else $error("line driver active in reset");
   a_flag_update: assert property (rx_subframe_i |=>
      rx_fault_flag_o == |($past(rx_fault_i) & ~$past(rx_fault_mask_i)))
      else $error("fault flag wrong after sub-frame");
   a_flag_hold: assert property (!rx_subframe_i |=> $stable(rx_fault_flag_o))
      else $error("fault flag moved between sub-frames");
   a_sync_out: assert property (sync_is_out_o && tx_subframe_i |=>
      block_start_sync_o == $past(tx_block_first_i)) else $error("sync output wrong");
   a_sync_oe: assert property (settled |-> block_start_sync_oe_o == sync_is_out_o)
      else $error("sync pin direction wrong");
   a_sync_in: assert property (s_sync_held |-> s_restart)
      else $error("held sync input gave no restart");
   a_no_restart: assert property (sync_is_out_o |-> !tx_block_restart_o)
      else $error("restart while sync is output");
   a_restart_slot: assert property (tx_block_restart_o |-> $past(tx_subframe_i))
      else $error("restart not at sub-frame");
   a_sda_open: assert property (!ctrl_spi_mode_o && ctrl_data_oe_o |-> !ctrl_data_o)
      else $error("data line driven high in I2C");
   a_spi_sticky: assert property (ctrl_spi_mode_o |=> ctrl_spi_mode_o)
      else $error("SPI selection lost");
   a_user_dir: assert property (side_pin_dir_bit_i [*4] |-> user_pin_oe_o)
      else $error("side pin not output");
   a_cfg_hold: assert property (settled |=> $stable(hw_mode_num_o) &&
      $stable(out_fmt_o) && $stable(in_fmt_o)) else $error("latched setup changed");
endmodule
bind hmss_top hmss_top_assertions u_chk (.mclk_i, .rst_n_i, .rx_fault_i, .rx_fault_mask_i,
   .rx_subframe_i, .rx_fault_flag_o, .tx_subframe_i, .tx_block_first_i, .block_start_sync_i,
   .block_start_sync_o, .block_start_sync_oe_o, .tx_block_restart_o, .sync_is_out_o,
   .line_driver_pos_o, .line_driver_neg_o, .ctrl_spi_mode_o, .ctrl_data_o, .ctrl_data_oe_o,
   .side_pin_dir_bit_i, .user_pin_oe_o, .hw_mode_num_o, .out_fmt_o, .in_fmt_o);
`default_nettype wire

/* tb/hmss_link_model.sv */
`timescale 1ns/1ps
`default_nettype none
module hmss_link_model #(
   parameter int BLK = 6
) (
   input  wire logic mclk_i,
   output var logic  tx_subframe_o = 1'b0,
   output var logic  tx_block_first_o = 1'b1,
   output var logic  sync_pin_o = 1'b0
);
   logic       lclk = 1'b0;
   logic [2:0] lsync_r = 3'h0;
   int         sf_cnt = 0;
   // Phase offset keeps the link clock unrelated to mclk
   initial begin
      #37;
      forever #80 lclk = ~lclk;
   end
   always @(posedge mclk_i) begin
      lsync_r <= {lsync_r[1:0], lclk};
      tx_subframe_o <= lsync_r[1] & ~lsync_r[2];
      if (tx_subframe_o) begin
         sf_cnt <= (sf_cnt == BLK - 1) ? 0 : sf_cnt + 1;
         tx_block_first_o <= (sf_cnt == BLK - 1);
      end
   end
   task automatic hold_sync(input int n);
      repeat (n) @(posedge mclk_i) sync_pin_o <= 1'b1;
      @(posedge mclk_i) sync_pin_o <= 1'b0;
   endtask
endmodule
`default_nettype wire

/* tb/hw_mode_strap_and_status_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "hmss_defines.vh"
`define HMSS_CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_total++; \
   $display("mismatch %s exp %h got %h", nm, ex, got); end end
module hw_mode_strap_and_status_tb;
   logic       mclk_i = 1'b0, rst_n_i = 1'b0, hw_mode_strap_i = 1'b0, flow_select_lo_i = 1'b0;
   logic       flow_select_hi_i = 1'b0, src_serial_sel_i = 1'b0, strap_out_master_i = 1'b0;
   logic       strap_sync_out_i = 1'b0, preemphasis_indicator_i = 1'b0, rx_subframe_i = 1'b0;
   logic       addr_pin_zero_i = 1'b0, addr_pin_one_i = 1'b0, side_pin_dir_bit_i = 1'b0;
   logic       sync_out_sw_i = 1'b0, line_driver_pos_i = 1'b0, line_driver_neg_i = 1'b0;
   logic       ctrl_sda_drive_low_i = 1'b0, ctrl_serial_out_i = 1'b0, user_data_rx_i = 1'b0;
   logic       user_pin_i = 1'b0, seen = 1'b0, exp_b = 1'b0;
   logic [1:0] strap_out_fmt_i = 2'h0, strap_in_fmt_i = 2'h0;
   logic [6:0] rx_fault_i = 7'h00, rx_fault_mask_i = 7'h00;
   logic [2:0] rx_preemphasis_indicator_code_i = 3'h0;
   logic [6:0] oft[4] = '{`HMSS_OF1, `HMSS_OF2, `HMSS_OF3, `HMSS_OF4};
   logic [6:0] ift[4] = '{`HMSS_IF1, `HMSS_IF2, `HMSS_IF3, `HMSS_IF4};
   wire        tx_subframe_i, tx_block_first_i, sync_pin, block_start_sync_i;
   wire        block_start_sync_o, block_start_sync_oe_o, tx_block_restart_o, line_driver_pos_o;
   wire        line_driver_neg_o, ctrl_data_o, ctrl_data_oe_o, ctrl_spi_mode_o, spi_chip_sel_n_o;
   wire        spi_data_in_o, user_pin_o, user_pin_oe_o, user_data_tx_o, rx_fault_flag_o;
   wire        preemphasis_indicator_o, preemphasis_indicator_oe_o, hw_mode_o, out_master_o;
   wire        out_fmt_bad_o, sync_is_out_o;
   wire [2:0]  i2c_addr_o, hw_mode_num_o;
   wire [6:0]  out_fmt_o, in_fmt_o;
   int         err_total = 0, num_checks = 0, cyc = 0, n_rst = 0, seed = 32'hb250_cf8c;
   logic       exp_q[$];
   always #2.5 mclk_i = ~mclk_i;
   // Pin level is the design's while it drives, else the far side's
   assign block_start_sync_i = block_start_sync_oe_o ? block_start_sync_o : sync_pin;
   hmss_top dut (.*);
   hmss_link_model u_link (.mclk_i, .tx_subframe_o(tx_subframe_i),
      .tx_block_first_o(tx_block_first_i), .sync_pin_o(sync_pin));
   // ----------------------------------------
   // Background traffic, restarts and timeout
   // ----------------------------------------
   always @(posedge mclk_i) begin
      cyc <= cyc + 1;
      {line_driver_pos_i, line_driver_neg_i, ctrl_sda_drive_low_i, ctrl_serial_out_i,
         user_data_rx_i, user_pin_i, sync_out_sw_i} <= 7'($random(seed));
      if (tx_block_restart_o) n_rst <= n_rst + 1;
      if (cyc == 20000) begin
         err_total++;
         summarize();
      end
   end
   // Flag result one cycle after each sub-frame strobe
   always @(posedge mclk_i) begin
      if (seen && exp_q.size() > 0) begin
         exp_b = exp_q.pop_front();
         `HMSS_CHK("rx_fault_flag_o", exp_b, rx_fault_flag_o)
      end
      seen = rx_subframe_i;
   end
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   task automatic pulse_sf(input logic [6:0] f, input logic [6:0] m);
      @(posedge mclk_i);
      rx_fault_i <= f;
      rx_fault_mask_i <= m;
      rx_subframe_i <= 1'b1;
      exp_q.push_back(|(f & ~m));
      @(posedge mclk_i);
      rx_subframe_i <= 1'b0;
      rx_fault_i <= 7'($random(seed));
   endtask
   task automatic cfg(input int c, input logic so);
      logic [2:0] en;
      @(posedge mclk_i);
      rst_n_i <= 1'b0;
      hw_mode_strap_i <= (c < 8);
      {flow_select_hi_i, flow_select_lo_i, src_serial_sel_i} <= c[2:0];
      {strap_out_master_i, strap_out_fmt_i, strap_in_fmt_i, preemphasis_indicator_i,
         addr_pin_one_i, side_pin_dir_bit_i} <= 8'($random(seed));
      strap_sync_out_i <= so;
      tick(4);
      rst_n_i <= 1'b1;
      tick(10);
      case (c[2:1])
         2'h0: en = 3'h1 + 3'(c[0]);
         2'h1: en = 3'h3;
         2'h2: en = 3'h4;
         default: en = 3'h5 + 3'(c[0]);
      endcase
      `HMSS_CHK("i2c_addr_o", {preemphasis_indicator_i, addr_pin_one_i, 1'b0}, i2c_addr_o)
      `HMSS_CHK("preemphasis_indicator_oe_o", 1'b1, preemphasis_indicator_oe_o)
      `HMSS_CHK("hw_mode_o", hw_mode_strap_i, hw_mode_o)
      `HMSS_CHK("hw_mode_num_o", (c < 8) ? en : 3'h0, hw_mode_num_o)
      if (c < 8) begin
         `HMSS_CHK("out_fmt_o", (en == 3'h4) ? `HMSS_OF5 : oft[strap_out_fmt_i], out_fmt_o)
         `HMSS_CHK("in_fmt_o", ift[strap_in_fmt_i], in_fmt_o)
         `HMSS_CHK("out_master_o", strap_out_master_i, out_master_o)
         `HMSS_CHK("sync_is_out_o", so, sync_is_out_o)
         if (en != 3'h4)
            `HMSS_CHK("out_fmt_bad_o", strap_out_fmt_i == 2'h2 && !strap_out_master_i, out_fmt_bad_o)
      end
      {strap_out_master_i, strap_out_fmt_i, strap_in_fmt_i, flow_select_lo_i} <= 6'($random(seed));
   endtask
   task automatic summarize();
      if (err_total == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      tick(12);
      for (int c = 0; c < 9; c++) cfg(c, 1'(c));
      cfg(0, 1'b1);
      tick(200);
      `HMSS_CHK("block_start_sync_oe_o", 1'b1, block_start_sync_oe_o)
      cfg(1, 1'b0);
      u_link.hold_sync(2);
      tick(80);
      `HMSS_CHK("restart count", 0, n_rst)
      u_link.hold_sync(5);
      tick(80);
      `HMSS_CHK("restart count", 1, n_rst)
      for (int i = 0; i < 14; i++) pulse_sf(7'h01 << (i % 7), (i < 7) ? 7'h00 : 7'h01 << (i % 7));
      for (int i = 0; i < 30; i++) pulse_sf(7'($random(seed)), 7'($random(seed)));
      for (int e = 0; e < 8; e++) begin
         rx_preemphasis_indicator_code_i <= 3'(e);
         pulse_sf(7'h00, 7'h00);
         pulse_sf(7'h00, 7'h00);
         tick(2);
         `HMSS_CHK("preemphasis_indicator_o", e != 1, preemphasis_indicator_o)
      end
      `HMSS_CHK("ctrl_spi_mode_o", 1'b0, ctrl_spi_mode_o)
      addr_pin_zero_i <= 1'b1;
      tick(5);
      addr_pin_zero_i <= 1'b0;
      tick(8);
      `HMSS_CHK("ctrl_spi_mode_o", 1'b1, ctrl_spi_mode_o)
      `HMSS_CHK("spi_chip_sel_n_o", 1'b0, spi_chip_sel_n_o)
      `HMSS_CHK("spi_data_in_o", addr_pin_one_i, spi_data_in_o)
      summarize();
   end
endmodule
`default_nettype wire
